/* File: verification/fcs_array_model.sv */
`timescale 1ns/1ps
module fcs_array_model #(
  parameter ADDR_W = 19
) (
  // clock
  input wire clk,
  // array port
  input wire [ADDR_W-1:0] arrAddr,
  output wire [7:0] arrRdData,
  input wire [7:0] arrWrData,
  input wire arrProgram,
  input wire arrErase,
  input wire [ADDR_W-1:0] arrEraseLo,
  input wire [ADDR_W-1:0] arrEraseHi
);
  reg [7:0] mem [0:(1<<ADDR_W)-1];
  integer i;
  initial
  begin
    for (i = 0; i < (1 << ADDR_W); i = i + 1)
      mem[i] = 8'hff;
  end
  assign arrRdData = mem[arrAddr];
  // cells only fall to 0 when programmed
  always @(posedge clk)
  begin
    if (arrProgram)
      mem[arrAddr] <= mem[arrAddr] & arrWrData;
    if (arrErase)
      for (i = arrEraseLo; i <= arrEraseHi; i = i + 1)
        mem[i] <= 8'hff;
  end
endmodule // fcs_array_model

/* File: verification/fcs_chk.sv */
`timescale 1ns/1ps
module fcs_chk #(
  parameter ADDR_W = 19
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // watched pins
  input wire interfaceSelect,
  input wire hubWrite,
  input wire parOutGate_n,
  input wire parDataOe,
  input wire parReadyBusy_n,
  input wire arrProgram,
  input wire arrErase,
  input wire [ADDR_W-1:0] arrEraseLo,
  input wire [ADDR_W-1:0] arrEraseHi
);
  // ---------------
  // properties
  // ---------------
  localparam int MAXB = 200;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_reset_idle: assert property (
    $fell(rst) |-> parReadyBusy_n && !arrProgram && !arrErase)
    else $error("outputs not idle after reset");
  a_busy_bound: assert property (
    $fell(parReadyBusy_n) |-> ##[1:MAXB] parReadyBusy_n)
    else $error("busy never ended");
  a_busy_cause: assert property (
    $fell(parReadyBusy_n) |-> $past(hubWrite) || $past(hubWrite, 2) ||
      $past(hubWrite, 3) || interfaceSelect || $past(interfaceSelect, 4))
    else $error("busy without a write");
  a_prog_at_end: assert property (
    arrProgram |-> !$past(parReadyBusy_n) || !$past(parReadyBusy_n, 2))
    else $error("program pulse outside busy");
  a_erase_range: assert property (
    arrErase |-> arrEraseLo[12:0] == 13'h0 && &arrEraseHi[12:0] &&
      arrEraseLo[18:16] == arrEraseHi[18:16] && arrEraseLo < arrEraseHi)
    else $error("erase range not a sector");
  a_pulse_single: assert property (
    (arrProgram || arrErase) |=> !arrProgram && !arrErase)
    else $error("array pulse too long");
  a_oe_gate_off: assert property (
    parOutGate_n [*4] |-> !parDataOe)
    else $error("driving with gate off");
  a_oe_mode_off: assert property (
    !interfaceSelect [*4] |-> !parDataOe)
    else $error("driving in hub mode");
  c_prog: cover property (arrProgram);
  c_erase: cover property (arrErase);
  c_par_read: cover property (parDataOe);
endmodule // fcs_chk

bind flash_command_sequencer fcs_chk #(.ADDR_W(ADDR_W)) i_fcs_chk (
  .clk(clk), .rst(rst), .interfaceSelect(interfaceSelect),
  .hubWrite(hubWrite), .parOutGate_n(parOutGate_n), .parDataOe(parDataOe),
  .parReadyBusy_n(parReadyBusy_n), .arrProgram(arrProgram),
  .arrErase(arrErase), .arrEraseLo(arrEraseLo), .arrEraseHi(arrEraseHi));

/* File: verification/flash_command_sequencer_tb.sv */
`timescale 1ns/1ps
module flash_command_sequencer_tb;
  // ---------------
  // bench
  // ---------------
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg ifSel = 1'b0;
  reg topGuard_n = 1'b1;
  reg otherGuard_n = 1'b1;
  reg rowCol = 1'b1;
  reg [10:0] parAddr = 11'h000;
  reg supplyOk = 1'b1;
  reg [7:0] lock = 8'h00;
  reg hubWrite = 1'b0;
  reg hubRead = 1'b0;
  reg [18:0] hubAddr = 19'h0;
  reg [7:0] hubWrData = 8'h00;
  reg outGate_n = 1'b1;
  reg write_n = 1'b1;
  reg [7:0] parIn = 8'h00;
  wire [7:0] hubRdData, parDataOut, arrRdData, arrWrData;
  wire [18:0] arrAddr, arrEraseLo, arrEraseHi;
  wire parDataOe, parReadyBusy_n, arrProgram, arrErase;
  integer mismatches = 0;
  integer total_checks = 0;
  integer cycles = 0;
  always #20 clk = ~clk;
  flash_command_sequencer #(.MFR_CODE(8'h3c), .DEV_CODE(8'hc3))
  i_flash_command_sequencer (
    .clk(clk), .rst(rst), .interfaceSelect(ifSel),
    .topSectorGuard_n(topGuard_n), .otherSectorGuard_n(otherGuard_n),
    .supplyOk(supplyOk), .sectorWriteLock(lock), .hubWrite(hubWrite),
    .hubRead(hubRead), .hubAddr(hubAddr), .hubWrData(hubWrData),
    .hubRdData(hubRdData), .parRowCol(rowCol), .parOutGate_n(outGate_n),
    .parWrite_n(write_n), .parReset_n(1'b1), .parAddr(parAddr),
    .parDataIn(parIn), .parDataOut(parDataOut), .parDataOe(parDataOe),
    .parReadyBusy_n(parReadyBusy_n), .arrAddr(arrAddr),
    .arrRdData(arrRdData), .arrWrData(arrWrData), .arrProgram(arrProgram),
    .arrErase(arrErase), .arrEraseLo(arrEraseLo), .arrEraseHi(arrEraseHi));
  fcs_array_model i_fcs_array_model (
    .clk(clk), .arrAddr(arrAddr), .arrRdData(arrRdData),
    .arrWrData(arrWrData), .arrProgram(arrProgram), .arrErase(arrErase),
    .arrEraseLo(arrEraseLo), .arrEraseHi(arrEraseHi));
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // writes are spaced by an idle edge so the strobe never toggles twice
  task wr(input [18:0] a, input [7:0] d);
    begin
      @(posedge clk);
      #1;
      hubAddr = a;
      hubWrData = d;
      hubWrite = 1'b1;
      @(posedge clk);
      #1;
      hubWrite = 1'b0;
    end
  endtask
  task rd(input [18:0] a, input [7:0] e, input [7:0] m = 8'hff);
    begin
      @(posedge clk);
      #1;
      hubAddr = a;
      hubRead = 1'b1;
      @(posedge clk);
      #1;
      hubRead = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(hubRdData & m, e);
    end
  endtask
  task wait_rdy;
    integer n;
    begin
      n = 0;
      repeat (3) @(posedge clk);
      #1;
      while (parReadyBusy_n !== 1'b1 && n < 300)
      begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk({7'h0, parReadyBusy_n}, 8'h01);
    end
  endtask
  // two-cycle command, then status check and flag clear
  task op(input [18:0] a, input [7:0] c, input [18:0] b, input [7:0] d,
    input [7:0] st);
    begin
      wr(a, c);
      wr(b, d);
      wait_rdy;
      wr(19'h0, 8'h70);
      rd(19'h0, st);
      wr(19'h0, 8'h50);
    end
  endtask
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles > 20000)
    begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(19'h12345, 8'hff);
    wr(19'h12345, 8'h40);
    wr(19'h12345, 8'h5a);
    wr(19'h0, 8'hff);
    wr(19'h0, 8'h70);
    rd(19'h0, 8'h00, 8'h80);
    wait_rdy;
    rd(19'h0, 8'h80);
    wr(19'h0, 8'hff);
    rd(19'h12345, 8'h5a);
    op(19'h12345, 8'h10, 19'h12345, 8'h0f, 8'h80);
    wr(19'h0, 8'hff);
    rd(19'h12345, 8'h0a);
    op(19'h1a000, 8'h20, 19'h1fff0, 8'hd0, 8'h80);
    wr(19'h0, 8'hff);
    rd(19'h12345, 8'hff);
    op(19'h74010, 8'h40, 19'h74010, 8'h00, 8'h80);
    op(19'h76010, 8'h40, 19'h76010, 8'h00, 8'h80);
    op(19'h75fff, 8'h21, 19'h74000, 8'hd0, 8'h80);
    wr(19'h0, 8'hff);
    rd(19'h74010, 8'hff);
    rd(19'h76010, 8'h00);
    lock = 8'h04;
    op(19'h20000, 8'h40, 19'h20000, 8'h00, 8'h92);
    lock = 8'h00;
    topGuard_n = 1'b0;
    op(19'h70000, 8'h21, 19'h70000, 8'hd0, 8'ha2);
    op(19'h7c000, 8'h20, 19'h7c000, 8'hd0, 8'ha2);
    topGuard_n = 1'b1;
    otherGuard_n = 1'b0;
    op(19'h30000, 8'h40, 19'h30000, 8'h00, 8'h92);
    otherGuard_n = 1'b1;
    op(19'h0, 8'h20, 19'h0, 8'hff, 8'hb0);
    supplyOk = 1'b0;
    op(19'h30000, 8'h40, 19'h30000, 8'h00, 8'h98);
    supplyOk = 1'b1;
    op(19'h30000, 8'h40, 19'h30000, 8'h00, 8'h80);
    wr(19'h0, 8'h90);
    rd(19'h00000, 8'h3c);
    rd(19'h00001, 8'hc3);
    wr(19'h0, 8'hff);
    rd(19'h00001, 8'hff);
    wr(19'h30000, 8'h20);
    wr(19'h30000, 8'hd0);
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    chk({7'h0, parReadyBusy_n}, 8'h01);
    rd(19'h30000, 8'h00);
    wr(19'h0, 8'h70);
    rd(19'h0, 8'h80);
    ifSel = 1'b1;
    parIn = 8'h90;
    repeat (4) @(posedge clk);
    #1;
    write_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    write_n = 1'b1;
    outGate_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk({7'h0, parDataOe}, 8'h01);
    chk(parDataOut, 8'h3c);
    parAddr = 11'h001;
    rowCol = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    parAddr = 11'h000;
    rowCol = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(parDataOut, 8'hc3);
    outGate_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk({7'h0, parDataOe}, 8'h00);
    finish_test;
  end
endmodule // flash_command_sequencer_tb

/* File: verilog/fcs_op_timer.v */
`timescale 1ns/1ps
module fcs_op_timer #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire start,
  input wire [WIDTH-1:0] length,
  output wire done
);
  reg [WIDTH-1:0] count_q;
  reg running_q;

  assign done = running_q && (count_q == {WIDTH{1'b0}});

  always @(posedge clk)
  begin
    if (rst)
    begin
      count_q <= {WIDTH{1'b0}};
      running_q <= 1'b0;
    end
    else if (start)
    begin
      count_q <= length;
      running_q <= 1'b1;
    end
    else if (running_q)
    begin
      if (count_q == {WIDTH{1'b0}})
        running_q <= 1'b0;
      else
        count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // fcs_op_timer

/* File: verilog/fcs_regs.vh */
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
// command codes
`define FCS_CMD_READ_ARRAY 8'hff
`define FCS_CMD_ERASE_MAIN 8'h20
`define FCS_CMD_ERASE_SUB 8'h21
`define FCS_CMD_PROG_A 8'h40
`define FCS_CMD_PROG_B 8'h10
`define FCS_CMD_IDENT 8'h90
`define FCS_CMD_STATUS 8'h70
`define FCS_CMD_CLEAR 8'h50
`define FCS_CMD_CONFIRM 8'hd0
// status bit positions
`define FCS_ST_READY 7
`define FCS_ST_ERASE_ERR 5
`define FCS_ST_PROG_ERR 4
`define FCS_ST_SUPPLY_LOW 3
`define FCS_ST_PROTECT 1
// identification addresses
`define FCS_ID_MFR_ADDR 19'h00000
`define FCS_ID_DEV_ADDR 19'h00001
// top sector sub-sector bounds
`define FCS_TOP_SECTOR 3'h7
`define FCS_SUB0_END 19'h73fff
`define FCS_SUB1_END 19'h75fff
`define FCS_SUB2_END 19'h77fff
// operation timing
`define FCS_PROG_TIME_NS 1000
`define FCS_ERASE_TIME_NS 4000
`define FCS_CLK_NS 40
`endif

/* File: verilog/flash_command_sequencer.v */
`timescale 1ns/1ps
`include "fcs_regs.vh"
module flash_command_sequencer #(
  parameter ADDR_W = 19,
  parameter MFR_CODE = 8'h5a, // arbitrary value
  parameter DEV_CODE = 8'ha5, // arbitrary value
  parameter PROG_CYCLES = (`FCS_PROG_TIME_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS,
  parameter ERASE_CYCLES = (`FCS_ERASE_TIME_NS + `FCS_CLK_NS - 1) /
    `FCS_CLK_NS
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // interface choice, protect and supply pins
  input wire interfaceSelect,
  input wire topSectorGuard_n,
  input wire otherSectorGuard_n,
  input wire supplyOk,
  input wire [7:0] sectorWriteLock,
  // hub side request port
  input wire hubWrite,
  input wire hubRead,
  input wire [ADDR_W-1:0] hubAddr,
  input wire [7:0] hubWrData,
  output reg [7:0] hubRdData,
  // parallel programming pins
  input wire parRowCol,
  input wire parOutGate_n,
  input wire parWrite_n,
  input wire parReset_n,
  input wire [10:0] parAddr,
  input wire [7:0] parDataIn,
  output reg [7:0] parDataOut,
  output wire parDataOe,
  output wire parReadyBusy_n,
  // flash array port
  output reg [ADDR_W-1:0] arrAddr,
  input wire [7:0] arrRdData,
  output reg [7:0] arrWrData,
  output reg arrProgram,
  output reg arrErase,
  output reg [ADDR_W-1:0] arrEraseLo,
  output reg [ADDR_W-1:0] arrEraseHi
);
  // ----------------------------------------------------------------
  // read modes and sequencer states
  // ----------------------------------------------------------------
  localparam [1:0] RD_ARRAY = 2'h0;
  localparam [1:0] RD_STATUS = 2'h1;
  localparam [1:0] RD_IDENT = 2'h2;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ERASE_SETUP = 2'h1;
  localparam [1:0] ST_PROG_SETUP = 2'h2;
  localparam [1:0] ST_BUSY = 2'h3;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [5:0] pinMeta_q;
  reg [5:0] pinSync_q;
  reg [10:0] parAddrMeta_q;
  reg [10:0] parAddrSync_q;
  reg [7:0] parDataMeta_q;
  reg [7:0] parDataSync_q;
  reg parRowColD_q;
  reg parWriteD_q;
  reg [10:0] rowAddr_q;
  reg [7:0] colAddr_q;
  reg [1:0] slowMeta_q;
  reg [1:0] slowSync_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      // select resets low so no false parallel mode follows reset
      pinMeta_q <= 6'h1f;
      pinSync_q <= 6'h1f;
      slowMeta_q <= 2'h3;
      slowSync_q <= 2'h3;
      parAddrMeta_q <= 11'h000;
      parAddrSync_q <= 11'h000;
      parDataMeta_q <= 8'h00;
      parDataSync_q <= 8'h00;
      parRowColD_q <= 1'b1;
      parWriteD_q <= 1'b1;
      rowAddr_q <= 11'h000;
      colAddr_q <= 8'h00;
    end
    else
    begin
      pinMeta_q <= {interfaceSelect, topSectorGuard_n, parRowCol,
        parOutGate_n, parWrite_n, parReset_n};
      pinSync_q <= pinMeta_q;
      slowMeta_q <= {supplyOk, otherSectorGuard_n};
      slowSync_q <= slowMeta_q;
      parAddrMeta_q <= parAddr;
      parAddrSync_q <= parAddrMeta_q;
      parDataMeta_q <= parDataIn;
      parDataSync_q <= parDataMeta_q;
      parRowColD_q <= pinSync_q[3];
      parWriteD_q <= pinSync_q[1];
      if (parRowColD_q && !pinSync_q[3])
        rowAddr_q <= parAddrSync_q;
      if (!parRowColD_q && pinSync_q[3])
        colAddr_q <= parAddrSync_q[7:0];
    end
  end

  wire parMode = pinSync_q[5];
  wire guardTop_n = pinSync_q[4];
  wire parGate_n = pinSync_q[2];
  wire parWe_n = pinSync_q[1];
  wire parRst_n = pinSync_q[0];
  wire supplyGood = slowSync_q[1];
  wire guardOther_n = slowSync_q[0];
  // a write is taken at the falling edge of the write strobe
  wire parWrEdge = parWriteD_q && !parWe_n && parRst_n;
  wire [ADDR_W-1:0] parFullAddr = {colAddr_q, rowAddr_q};

  // ----------------------------------------------------------------
  // request selection
  // ----------------------------------------------------------------
  wire wrStrobe = parMode ? parWrEdge : hubWrite;
  wire [ADDR_W-1:0] reqAddr = parMode ? parFullAddr : hubAddr;
  wire [7:0] reqData = parMode ? parDataSync_q : hubWrData;

  // ----------------------------------------------------------------
  // sector decode
  // ----------------------------------------------------------------
  function [2:0] sectorOf;
    input [ADDR_W-1:0] a;
    begin
      sectorOf = a[ADDR_W-1:ADDR_W-3];
    end
  endfunction

  function [ADDR_W-1:0] subLow;
    input [ADDR_W-1:0] a;
    begin
      if (a <= `FCS_SUB0_END)
        subLow = 19'h70000;
      else if (a <= `FCS_SUB1_END)
        subLow = `FCS_SUB0_END + 19'h00001;
      else if (a <= `FCS_SUB2_END)
        subLow = `FCS_SUB1_END + 19'h00001;
      else
        subLow = `FCS_SUB2_END + 19'h00001;
    end
  endfunction

  function [ADDR_W-1:0] subHigh;
    input [ADDR_W-1:0] a;
    begin
      if (a <= `FCS_SUB0_END)
        subHigh = `FCS_SUB0_END;
      else if (a <= `FCS_SUB1_END)
        subHigh = `FCS_SUB1_END;
      else if (a <= `FCS_SUB2_END)
        subHigh = `FCS_SUB2_END;
      else
        subHigh = 19'h7ffff;
    end
  endfunction

  wire [2:0] reqSector = sectorOf(reqAddr);
  // a guard pin or the lock register either one locks; lock read now, at start
  wire reqLocked = sectorWriteLock[reqSector] ||
    ((reqSector == `FCS_TOP_SECTOR) ? !guardTop_n :
    !guardOther_n);

  // ----------------------------------------------------------------
  // command decoder and write sequencer
  // ----------------------------------------------------------------
  reg [1:0] state_q;
  reg [1:0] readMode_q;
  reg subErase_q;
  reg isErase_q;
  reg eraseErr_q;
  reg progErr_q;
  reg supplyErr_q;
  reg protectErr_q;
  reg timerStart;
  reg [15:0] timerLen;
  wire timerDone;

  fcs_op_timer #(
    .WIDTH(16)
  ) opTimer (
    .clk(clk),
    .rst(rst),
    .start(timerStart),
    .length(timerLen),
    .done(timerDone)
  );

  wire isConfirm = reqData == `FCS_CMD_CONFIRM;

  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      readMode_q <= RD_ARRAY;
      subErase_q <= 1'b0;
      isErase_q <= 1'b0;
      eraseErr_q <= 1'b0;
      progErr_q <= 1'b0;
      supplyErr_q <= 1'b0;
      protectErr_q <= 1'b0;
      timerStart <= 1'b0;
      timerLen <= 16'h0000;
      arrAddr <= {ADDR_W{1'b0}};
      arrWrData <= 8'hff;
      arrProgram <= 1'b0;
      arrErase <= 1'b0;
      arrEraseLo <= {ADDR_W{1'b0}};
      arrEraseHi <= {ADDR_W{1'b0}};
    end
    else
    begin
      timerStart <= 1'b0;
      arrProgram <= 1'b0;
      arrErase <= 1'b0;
      // hold the program target until its pulse has gone out
      if (!wrStrobe && (hubRead || parMode) && state_q != ST_BUSY)
        arrAddr <= reqAddr;
      case (state_q)
        ST_IDLE:
        begin
          if (wrStrobe)
          begin
            case (reqData)
              `FCS_CMD_READ_ARRAY: readMode_q <= RD_ARRAY;
              `FCS_CMD_STATUS: readMode_q <= RD_STATUS;
              `FCS_CMD_IDENT: readMode_q <= RD_IDENT;
              `FCS_CMD_CLEAR:
              begin
                if (readMode_q == RD_IDENT)
                  readMode_q <= RD_ARRAY;
                eraseErr_q <= 1'b0;
                progErr_q <= 1'b0;
                supplyErr_q <= 1'b0;
                protectErr_q <= 1'b0;
              end
              `FCS_CMD_ERASE_MAIN, `FCS_CMD_ERASE_SUB:
              begin
                subErase_q <= reqData == `FCS_CMD_ERASE_SUB;
                readMode_q <= RD_STATUS;
                state_q <= ST_ERASE_SETUP;
              end
              `FCS_CMD_PROG_A, `FCS_CMD_PROG_B:
              begin
                readMode_q <= RD_STATUS;
                state_q <= ST_PROG_SETUP;
              end
              default: ;
            endcase
          end
        end
        ST_ERASE_SETUP:
        begin
          if (wrStrobe)
          begin
            isErase_q <= 1'b1;
            if (!isConfirm)
            begin
              eraseErr_q <= 1'b1;
              progErr_q <= 1'b1;
              state_q <= ST_IDLE;
            end
            else if (reqLocked)
            begin
              eraseErr_q <= 1'b1;
              protectErr_q <= 1'b1;
              state_q <= ST_IDLE;
            end
            else
            begin
              // sector from this second write's address
              if (subErase_q && reqSector == `FCS_TOP_SECTOR)
              begin
                arrEraseLo <= subLow(reqAddr);
                arrEraseHi <= subHigh(reqAddr);
              end
              else
              begin
                arrEraseLo <= {reqSector, {(ADDR_W-3){1'b0}}};
                arrEraseHi <= {reqSector, {(ADDR_W-3){1'b1}}};
              end
              timerLen <= ERASE_CYCLES[15:0];
              timerStart <= 1'b1;
              state_q <= ST_BUSY;
            end
          end
        end
        ST_PROG_SETUP:
        begin
          if (wrStrobe)
          begin
            isErase_q <= 1'b0;
            arrAddr <= reqAddr;
            arrWrData <= reqData;
            if (reqLocked)
            begin
              progErr_q <= 1'b1;
              protectErr_q <= 1'b1;
              state_q <= ST_IDLE;
            end
            else
            begin
              timerLen <= PROG_CYCLES[15:0];
              timerStart <= 1'b1;
              state_q <= ST_BUSY;
            end
          end
        end
        ST_BUSY:
        begin
          // array read and other commands ignored here
          if (wrStrobe && reqData == `FCS_CMD_STATUS)
            readMode_q <= RD_STATUS;
          if (timerDone)
          begin
            state_q <= ST_IDLE;
            if (!supplyGood)
            begin
              supplyErr_q <= 1'b1;
              if (isErase_q)
                eraseErr_q <= 1'b1;
              else
                progErr_q <= 1'b1;
            end
            else if (isErase_q)
              arrErase <= 1'b1;
            else
              arrProgram <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status and read data
  // ----------------------------------------------------------------
  wire ready = state_q != ST_BUSY;
  wire [7:0] operationStatus = {ready, 1'b0, eraseErr_q, progErr_q,
    supplyErr_q, 1'b0, protectErr_q, 1'b0};

  reg [7:0] readValue;
  always @*
  begin
    case (readMode_q)
      RD_STATUS: readValue = operationStatus;
      RD_IDENT:
        if (arrAddr == `FCS_ID_MFR_ADDR)
          readValue = MFR_CODE;
        else if (arrAddr == `FCS_ID_DEV_ADDR)
          readValue = DEV_CODE;
        else
          readValue = 8'h00;
      default: readValue = arrRdData;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      hubRdData <= 8'h00;
      parDataOut <= 8'h00;
    end
    else
    begin
      hubRdData <= readValue;
      parDataOut <= readValue;
    end
  end

  assign parDataOe = parMode && !parGate_n && parWe_n && parRst_n;
  assign parReadyBusy_n = ready;
endmodule // flash_command_sequencer
